// File: ext_bus_pkg.sv
package ext_bus_pkg;

    // ************************************************************
    // constants
    // ************************************************************
    localparam logic [15:0] INT_CODE_TOP   = 16'h3fff;
    localparam int          ALE_IDLE_CYCLES = 6;
    localparam logic [7:0]  P0_RESET       = 8'hff;
    localparam logic [7:0]  P2_RESET       = 8'hff;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0]
    {
        KIND_FETCH,
        KIND_TABLE,
        KIND_DREAD,
        KIND_DWRITE
    } kind_t;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_ADDR,
        ST_LATCH,
        ST_STROBE,
        ST_HOLD
    } bus_state_t;

endpackage

// File: external_memory_bus_interface.sv
`timescale 1ns/10ps
module external_memory_bus_interface
    import ext_bus_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       extAccessN,
    input  wire logic       latchStrobeOff,
    input  wire logic       reqValid,
    input  wire kind_t      reqKind,
    input  wire logic [15:0] reqAddr,
    input  wire logic [7:0] reqWrData,
    input  wire logic [7:0] intCodeData,
    input  wire logic [7:0] p0In,
    output logic            reqReady,
    output logic            respValid,
    output logic [7:0]      respData,
    output logic [7:0]      p0Out,
    output logic            p0OeN,
    output logic [7:0]      p2Out,
    output logic            addrLatchStrobe,
    output logic            programStoreStrobeN,
    output logic            readStrobeN,
    output logic            writeStrobeN
);

    // ************************************************************
    // request decode
    // ************************************************************
    bus_state_t  state;
    kind_t       curKind;
    logic        take;
    logic        isCode;
    logic        internalHit;
    logic        aleTick;
    logic [2:0]  aleCnt;

    assign take   = reqValid && reqReady;
    assign isCode = (reqKind == KIND_FETCH) || (reqKind == KIND_TABLE);
    assign internalHit = isCode && extAccessN && (reqAddr <= INT_CODE_TOP);

    // ************************************************************
    // idle latch strobe divider
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aleCnt  <= 3'h0;
            aleTick <= 1'b0;
        end
        else if (aleCnt == 3'(ALE_IDLE_CYCLES - 1))
        begin
            aleCnt  <= 3'h0;
            aleTick <= 1'b1;
        end
        else
        begin
            aleCnt  <= aleCnt + 3'h1;
            aleTick <= 1'b0;
        end
    end

    // ************************************************************
    // bus sequencer
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state               <= ST_IDLE;
            curKind             <= KIND_FETCH;
            reqReady            <= 1'b1;
            p0Out               <= P0_RESET;
            p0OeN               <= 1'b1;
            p2Out               <= P2_RESET;
            addrLatchStrobe     <= 1'b0;
            programStoreStrobeN <= 1'b1;
            readStrobeN         <= 1'b1;
            writeStrobeN        <= 1'b1;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    addrLatchStrobe <= aleTick && !latchStrobeOff;
                    if (take && !internalHit)
                    begin
                        state           <= ST_ADDR;
                        curKind         <= reqKind;
                        reqReady        <= 1'b0;
                        p0Out           <= reqAddr[7:0];
                        p0OeN           <= 1'b0;
                        p2Out           <= reqAddr[15:8];
                        addrLatchStrobe <= 1'b1;
                    end
                end
                ST_ADDR:
                begin
                    addrLatchStrobe <= 1'b0;
                    state           <= ST_LATCH;
                end
                ST_LATCH:
                begin
                    state <= ST_STROBE;
                    if (curKind == KIND_DWRITE)
                    begin
                        p0Out        <= reqWrData;
                        writeStrobeN <= 1'b0;
                    end
                    else
                    begin
                        p0OeN <= 1'b1;
                        if (curKind == KIND_DREAD)
                        begin
                            readStrobeN <= 1'b0;
                        end
                        else
                        begin
                            programStoreStrobeN <= 1'b0;
                        end
                    end
                end
                ST_STROBE:
                begin
                    state <= ST_HOLD;
                end
                default:
                begin
                    state               <= ST_IDLE;
                    reqReady            <= 1'b1;
                    p0OeN               <= 1'b1;
                    programStoreStrobeN <= 1'b1;
                    readStrobeN         <= 1'b1;
                    writeStrobeN        <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // answer to the core
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            respValid <= 1'b0;
            respData  <= 8'h00;
        end
        else if (state == ST_IDLE && take && internalHit)
        begin
            respValid <= 1'b1;
            respData  <= intCodeData;
        end
        else if (state == ST_HOLD)
        begin
            respValid <= 1'b1;
            respData  <= (curKind == KIND_DWRITE) ? 8'h00 : p0In;
        end
        else
        begin
            respValid <= 1'b0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    AST_EXT_FORCED: assert property (@(posedge mclk) disable iff (!reset_n)
        take && isCode && !extAccessN |=> addrLatchStrobe && !p0OeN)
        else $error("fetch with external access low stayed internal");

    AST_INT_NO_BUS: assert property (@(posedge mclk) disable iff (!reset_n)
        take && internalHit |=> respValid && p0OeN
        && !(addrLatchStrobe && $past(latchStrobeOff)))
        else $error("internal fetch showed on the bus");

    AST_PROG_STROBE_EXT: assert property (@(posedge mclk) disable iff (!reset_n)
        take && isCode && !internalHit |-> ##3 !programStoreStrobeN
        ##1 !programStoreStrobeN ##1 programStoreStrobeN && respValid)
        else $error("program store strobe pulse wrong");

    AST_PROG_STROBE_INT: assert property (@(posedge mclk) disable iff (!reset_n)
        take && internalHit |-> ##[1:5] programStoreStrobeN)
        else $error("strobe on internal access");

    AST_ALE_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        state == ST_LATCH |-> $fell(addrLatchStrobe) && !p0OeN
        && $stable(p0Out))
        else $error("low address not held past latch fall");

    AST_RD_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
        take && reqKind == KIND_DREAD |-> ##3 !readStrobeN && p0OeN
        ##1 !readStrobeN ##1 readStrobeN && respValid)
        else $error("read strobe pulse wrong");

    AST_WR_DATA: assert property (@(posedge mclk) disable iff (!reset_n)
        take && reqKind == KIND_DWRITE |-> ##3 !writeStrobeN && !p0OeN
        && p0Out == $past(reqWrData, 3))
        else $error("write data phase wrong");

    AST_P2_ADDR: assert property (@(posedge mclk) disable iff (!reset_n)
        take && !internalHit |=> p2Out == $past(reqAddr[15:8]))
        else $error("upper address not on port 2");

    AST_STROBE_OFF_IDLE: assert property (@(posedge mclk) disable iff (!reset_n)
        state == ST_IDLE && latchStrobeOff && !take |=> !addrLatchStrobe)
        else $error("latch strobe toggled while turned off");

    AST_STROBE_RESUME: assert property (@(posedge mclk) disable iff (!reset_n)
        take && !internalHit && latchStrobeOff |=> addrLatchStrobe
        ##1 !addrLatchStrobe)
        else $error("latch strobe did not resume for external access");

    AST_SPACE_SELECT: assert property (@(posedge mclk) disable iff (!reset_n)
        take && isCode |-> ##[1:5] readStrobeN && writeStrobeN)
        else $error("data strobe on code space access");

    AST_WR_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
        take && reqKind == KIND_DWRITE |-> ##4 !writeStrobeN
        ##1 writeStrobeN && p0OeN && respValid)
        else $error("write strobe pulse wrong");

endmodule

// File: ext_mem_model.sv
`timescale 1ns/10ps
module ext_mem_model
(
    input  wire logic       mclk,
    input  wire logic [7:0] p0Bus,
    input  wire logic [7:0] p2Out,
    input  wire logic       addrLatchStrobe,
    input  wire logic       programStoreStrobeN,
    input  wire logic       readStrobeN,
    input  wire logic       writeStrobeN,
    output logic [7:0]      p0Drv
);
    logic [7:0]  lowAddr = 8'h00;
    logic [7:0]  junk = 8'h00;
    logic [7:0]  ram [logic [15:0]];
    logic [15:0] ad;
    assign ad = {p2Out, lowAddr};
    always @(negedge addrLatchStrobe) lowAddr = p0Bus;
    always @(posedge mclk) if (!writeStrobeN) ram[ad] = p0Bus;
    always @(posedge mclk) junk <= junk + 8'h3b;
    always @*
        if (!programStoreStrobeN) p0Drv = ad[7:0] ^ ad[15:8] ^ 8'h5a;
        else if (!readStrobeN) p0Drv = ram.exists(ad) ? ram[ad] : 8'h00;
        else p0Drv = junk;
endmodule

// File: tb_top.sv
`timescale 1ns/10ps
module tb_top
    import ext_bus_pkg::*;
;
    logic        mclk = 1'b0, reset_n = 1'b0, extAccessN = 1'b1;
    logic        latchStrobeOff = 1'b1, reqValid = 1'b0;
    kind_t       reqKind = KIND_FETCH;
    logic [15:0] reqAddr = 16'h0000, a;
    logic [7:0]  reqWrData = 8'h00, intCodeData, p0Bus, p0Drv, p0Out;
    logic [7:0]  p2Out, respData, got;
    logic        reqReady, respValid, p0OeN, addrLatchStrobe;
    logic        programStoreStrobeN, readStrobeN, writeStrobeN;
    logic [16:0] seed = 17'h10364;
    logic [7:0]  mem [logic [15:0]];
    int          n_fail = 0, check_count = 0, nAle = 0, nPs = 0, p, q;
    always #50 mclk = ~mclk;
    assign p0Bus = !p0OeN ? p0Out : p0Drv;
    assign intCodeData = ~reqAddr[7:0];
    always @(posedge addrLatchStrobe) nAle++;
    always @(negedge programStoreStrobeN) nPs++;
    external_memory_bus_interface u_dut (.mclk, .reset_n, .extAccessN,
        .latchStrobeOff, .reqValid, .reqKind, .reqAddr, .reqWrData,
        .intCodeData, .p0In(p0Bus), .reqReady, .respValid, .respData,
        .p0Out, .p0OeN, .p2Out, .addrLatchStrobe, .programStoreStrobeN,
        .readStrobeN, .writeStrobeN);
    ext_mem_model u_mem (.mclk, .p0Bus, .p2Out, .addrLatchStrobe,
        .programStoreStrobeN, .readStrobeN, .writeStrobeN, .p0Drv);
    // ****************************************
    // checking
    // ****************************************
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // address phase on both ports
    always @(negedge addrLatchStrobe)
        if (reqReady === 1'b0)
            chk({p2Out, p0Bus}, reqAddr);
    task automatic run(input kind_t k, input logic [15:0] ad,
                       input logic [7:0] w);
        int  n;
        logic intl;
        logic [7:0] e;
        intl = k <= KIND_TABLE && extAccessN && ad <= INT_CODE_TOP;
        e = k == KIND_DWRITE ? 8'h00 :
            k == KIND_DREAD ? (mem.exists(ad) ? mem[ad] : 8'h00) :
            intl ? ~ad[7:0] : ad[7:0] ^ ad[15:8] ^ 8'h5a;
        @(negedge mclk);
        reqKind = k;
        reqAddr = ad;
        reqWrData = w;
        reqValid = 1'b1;
        p = nPs;
        q = nAle;
        @(negedge mclk);
        reqValid = 1'b0;
        n = 0;
        while (respValid !== 1'b1 && n < 10)
        begin
            @(negedge mclk);
            n++;
        end
        chk({14'h0, respValid, reqReady}, 16'h0003);
        chk({8'h00, respData}, {8'h00, e});
        chk(16'(nPs - p), {15'h0, !intl && k <= KIND_TABLE});
        chk(16'(nAle - q), {15'h0, !intl});
        if (k == KIND_DWRITE) mem[ad] = w;
    endtask
    initial
    begin
        repeat (5) @(negedge mclk);
        reset_n = 1'b1;
        for (int x = 1; x >= 0; x--)
        begin
            extAccessN = x[0];
            for (int k = 0; k < 2; k++)
            begin
                run(kind_t'(k), 16'h3fff, 8'h00);
                run(kind_t'(k), 16'h4000, 8'h00);
                run(kind_t'(k), 16'h0000, 8'h00);
            end
            repeat (6)
            begin
                seed = lfsr(seed);
                a = seed[15:0];
                seed = lfsr(seed);
                run(KIND_DWRITE, a, seed[7:0]);
                run(KIND_DREAD, a, 8'h00);
                run(KIND_FETCH, a, 8'h00);
            end
        end
        latchStrobeOff = 1'b0;
        @(negedge mclk);
        q = nAle;
        repeat (12) @(negedge mclk);
        chk(16'(nAle - q), 16'h0002);
        wrap_up;
    end
    initial
    begin
        #500000;
        n_fail++;
        wrap_up;
    end
endmodule
